//--- rtl/dlsc_pkg.sv
// shared constants and types of the dpll loop state controller
// assumes a single 50 MHz core clock; no software register map
package dlsc_pkg;
    localparam int TW_W = 32;            // tuning word width
    localparam int ACC_W = 48;           // average accumulator width
    localparam int INT_W = 4;            // averaging interval exponent width
    localparam int CNT_W = 16;           // averaging sample counter width
    localparam int NREF = 4;             // number of input references
    localparam int SEL_W = 2;            // reference index width
    localparam int FBI_W = 17;           // feedback integer divider width
    localparam int FBM_W = 23;           // feedback modulus width
    localparam int TMR_W = 8;            // state timer width
    localparam int STG_W = 2;            // recovery stage index width
    localparam int CLK_NS = 20;          // core clock period
    localparam int SW_HOLD_NS = 100;     // least switchover holdover time
    localparam int SW_HOLD_CYC = (SW_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int STEP_NS = 200;        // least time per recovery stage
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [STG_W-1:0] LAST_STAGE = 2'h2;
    localparam logic [TW_W-1:0] TW_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_FREE,
        ST_HOLD,
        ST_SWHOLD,
        ST_LOAD,
        ST_RECOVER,
        ST_CLOSED
    } dlsc_state_t;
endpackage : dlsc_pkg

//--- rtl/dlsc_avg_if.sv
// carrier between the loop controller and the tuning word averager
// assumes both ends sit on the same core clock
`timescale 1ns/10ps
interface dlsc_avg_if;
    logic sample_en;
    logic [dlsc_pkg::TW_W-1:0] sample;
    logic [dlsc_pkg::INT_W-1:0] interval_log2;
    logic clear;
    logic [dlsc_pkg::TW_W-1:0] average;
    logic hist_valid;
    modport avg (input sample_en, input sample, input interval_log2, input clear,
                 output average, output hist_valid);
    modport ctl (output sample_en, output sample, output interval_log2, output clear,
                 input average, input hist_valid);
endinterface : dlsc_avg_if

//--- rtl/dlsc_tw_avg.sv
// tuning word history: block average over 2**interval samples
// assumes the controller gates sample_en to closed-loop tracking only
`timescale 1ns/10ps
module dlsc_tw_avg (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    dlsc_avg_if.avg bus
);
    logic [dlsc_pkg::ACC_W-1:0] acc_q, acc_d, sum;
    logic [dlsc_pkg::CNT_W-1:0] cnt_q, cnt_d, limit;
    logic [dlsc_pkg::TW_W-1:0] avg_q, avg_d;
    logic vld_q, vld_d;

    ////////////////////////////////////////////////////////////////////////
    // accumulate; a power-of-two interval makes the divide a plain shift
    always_comb begin
        acc_d = acc_q;
        cnt_d = cnt_q;
        avg_d = avg_q;
        vld_d = vld_q;
        sum = acc_q + dlsc_pkg::ACC_W'(bus.sample);
        limit = (16'h0001 << bus.interval_log2) - 16'h0001;
        if (bus.clear) begin
            acc_d = '0;
            cnt_d = '0;
            vld_d = 1'b0;
        end else if (bus.sample_en) begin
            if (cnt_q >= limit) begin
                avg_d = dlsc_pkg::TW_W'(sum >> bus.interval_log2); // see R1
                acc_d = '0;
                cnt_d = '0;
                vld_d = 1'b1;
            end else begin
                acc_d = sum;
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            acc_q <= '0;
            cnt_q <= '0;
            avg_q <= dlsc_pkg::TW_RST;
            vld_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            avg_q <= avg_d;
            vld_q <= vld_d;
        end
    end

    assign bus.average = avg_q;
    assign bus.hist_valid = vld_q;

    ////////////////////////////////////////////////////////////////////////
    a_avg_frozen_idle: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R1
        !bus.sample_en |=> $stable(avg_q))
        else $error("average moved without a sample");
    a_hist_stays_valid: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R1
        vld_q && !bus.clear |=> vld_q)
        else $error("history valid dropped without clear");
endmodule : dlsc_tw_avg

//--- rtl/dlsc_loop_ctrl.sv
// loop control state machine of one digital pll
// assumes reference selection and validation happen outside; inputs are
// synchronous to i_core_clk
`timescale 1ns/10ps

// What this block does
// R1: average loop filter tuning words over the user interval as history.
// R2: in holdover drive the oscillator from the stored average tuning word.
// R3: on reference switch, brief holdover, load new profile, return to tracking.
// R4: hold lock detector outputs at pre-switch values throughout a switchover.
// R5: enter holdover when no reference is present or on user request.
// R6: in holdover keep output frequency constant, ignore phase samples.
// R7: leave holdover automatically when a valid reference appears, no user hold.
// R8: on exit restore closed loop, lock, step loop parameters per profile.
// R9: user holdover bit keeps the loop in holdover despite valid reference.
// R10: controller clears user holdover bit to allow automatic recovery; the code never clears it and waits until i_user_holdover drops from outside.
// R11: free run or holdover reports unlocked, except during a reference switch.
// R12: changed coefficients take effect only after the loop is opened.
// R13: divider integer or modulus change causes a brief holdover and recovery.
// R14: without history, holdover holds the free-run tuning word.
module dlsc_loop_ctrl (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [dlsc_pkg::NREF-1:0] i_ref_valid,
    input wire logic [dlsc_pkg::SEL_W-1:0] i_ref_sel,
    input wire logic i_user_holdover,
    input wire logic i_user_free_run,
    input wire logic i_tw_strobe,
    input wire logic [dlsc_pkg::TW_W-1:0] i_loop_tw,
    input wire logic [dlsc_pkg::TW_W-1:0] i_freerun_tw,
    input wire logic [dlsc_pkg::INT_W-1:0] i_avg_interval,
    input wire logic [dlsc_pkg::FBI_W-1:0] i_fb_int,
    input wire logic [dlsc_pkg::FBM_W-1:0] i_fb_mod,
    input wire logic i_phase_lock_raw,
    input wire logic i_freq_lock_raw,
    output logic [dlsc_pkg::TW_W-1:0] o_dco_tw,
    output logic o_loop_closed,
    output logic o_holdover,
    output logic o_free_run,
    output logic o_switching,
    output logic o_profile_load,
    output logic [dlsc_pkg::SEL_W-1:0] o_profile_idx,
    output logic [dlsc_pkg::STG_W-1:0] o_recover_stage,
    output logic o_phase_lock,
    output logic o_freq_lock,
    output logic o_hist_valid
);
    dlsc_pkg::dlsc_state_t st_q, st_d;
    logic [dlsc_pkg::TMR_W-1:0] tmr_q, tmr_d;
    logic [dlsc_pkg::STG_W-1:0] stage_d;
    logic [dlsc_pkg::SEL_W-1:0] ref_d;
    logic keep_q, keep_d;
    logic [dlsc_pkg::FBI_W-1:0] fbi_q;
    logic [dlsc_pkg::FBM_W-1:0] fbm_q;
    logic sel_ok, hold_req, fb_chg;
    logic [dlsc_pkg::TW_W-1:0] dco_d;
    logic closed_d, hold_d, free_d, load_d, smp_q, smp_d;
    logic [1:0] lk_q, lk_d, lk_raw;

    dlsc_avg_if avg_bus ();

    // states in which the oscillator runs open loop on a held word
    function automatic logic is_hold(input dlsc_pkg::dlsc_state_t s);
        is_hold = (s == dlsc_pkg::ST_HOLD) || (s == dlsc_pkg::ST_SWHOLD) ||
                  (s == dlsc_pkg::ST_LOAD);
    endfunction : is_hold

    // states in which the loop tracks the reference
    function automatic logic is_track(input dlsc_pkg::dlsc_state_t s);
        is_track = (s == dlsc_pkg::ST_RECOVER) || (s == dlsc_pkg::ST_CLOSED);
    endfunction : is_track

    ////////////////////////////////////////////////////////////////////////
    // request decode
    assign sel_ok = i_ref_valid[i_ref_sel];
    assign hold_req = i_user_holdover || !sel_ok; // see R5 see R9
    assign fb_chg = (i_fb_int != fbi_q) || (i_fb_mod != fbm_q);

    ////////////////////////////////////////////////////////////////////////
    // loop state: next value
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q;
        stage_d = o_recover_stage;
        keep_d = keep_q;
        ref_d = o_profile_idx;
        case (st_q)
            dlsc_pkg::ST_FREE: begin
                if (!i_user_free_run && !hold_req) begin
                    st_d = dlsc_pkg::ST_LOAD;
                end else if (!i_user_free_run) begin
                    st_d = dlsc_pkg::ST_HOLD;
                end
            end
            dlsc_pkg::ST_HOLD: begin
                if (!hold_req) begin
                    st_d = dlsc_pkg::ST_LOAD; // see R7 see R10
                end
            end
            dlsc_pkg::ST_SWHOLD: begin
                if (tmr_q == dlsc_pkg::TMR_W'(dlsc_pkg::SW_HOLD_CYC - 1)) begin
                    st_d = dlsc_pkg::ST_LOAD; // see R3
                end else begin
                    tmr_d = tmr_q + 8'h01;
                end
            end
            dlsc_pkg::ST_LOAD: begin
                st_d = dlsc_pkg::ST_RECOVER;
                tmr_d = '0;
                stage_d = '0;
            end
            dlsc_pkg::ST_RECOVER: begin
                // stage index drives the profile's stepped loop parameters
                if (tmr_q == dlsc_pkg::TMR_W'(dlsc_pkg::STEP_CYC - 1)) begin
                    tmr_d = '0;
                    if (o_recover_stage == dlsc_pkg::LAST_STAGE) begin
                        st_d = dlsc_pkg::ST_CLOSED; // see R8
                        keep_d = 1'b0;
                    end else begin
                        stage_d = o_recover_stage + 2'h1; // see R8
                    end
                end else begin
                    tmr_d = tmr_q + 8'h01;
                end
            end
            dlsc_pkg::ST_CLOSED: begin
                // a divider change reuses the switchover path: no lock glitch
                if ((i_ref_sel != o_profile_idx) || fb_chg) begin
                    st_d = dlsc_pkg::ST_SWHOLD; // see R3 see R13
                    keep_d = 1'b1; // see R4
                    tmr_d = '0;
                end
            end
            default: begin
                st_d = dlsc_pkg::ST_FREE;
            end
        endcase
        // user free run and loss of reference override any open sequence
        if (st_q != dlsc_pkg::ST_FREE) begin
            if (i_user_free_run) begin
                st_d = dlsc_pkg::ST_FREE;
                keep_d = 1'b0;
            end else if (hold_req) begin
                st_d = dlsc_pkg::ST_HOLD; // see R5 see R9
                keep_d = 1'b0;
            end
        end
        if (st_d == dlsc_pkg::ST_LOAD) begin
            ref_d = i_ref_sel; // see R8
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_q <= dlsc_pkg::ST_FREE;
            tmr_q <= '0;
            o_recover_stage <= '0;
            keep_q <= 1'b0;
            o_profile_idx <= '0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            o_recover_stage <= stage_d;
            keep_q <= keep_d;
            o_profile_idx <= ref_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator word and mode outputs, decoded from the next state so they
    // line up with the state register
    always_comb begin
        dco_d = o_dco_tw;
        if (st_d == dlsc_pkg::ST_FREE) begin
            dco_d = i_freerun_tw;
        end else if (is_track(st_d)) begin
            if (i_tw_strobe) begin
                dco_d = i_loop_tw;
            end
        end else if (!is_hold(st_q)) begin
            // word is frozen at entry; later samples are ignored
            dco_d = avg_bus.hist_valid ? avg_bus.average : i_freerun_tw; // see R2 see R14
        end
        closed_d = is_track(st_d);
        hold_d = is_hold(st_d); // see R6
        free_d = (st_d == dlsc_pkg::ST_FREE);
        load_d = (st_d == dlsc_pkg::ST_LOAD); // see R12
        // a strobe in the cycle that leaves tracking is dropped, so no sample
        // is still in flight once holdover is shown
        smp_d = (st_q == dlsc_pkg::ST_CLOSED) && (st_d == dlsc_pkg::ST_CLOSED) &&
                i_tw_strobe; // see R1 see R6
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_dco_tw <= dlsc_pkg::TW_RST;
            o_loop_closed <= 1'b0;
            o_holdover <= 1'b0;
            o_free_run <= 1'b1;
            o_switching <= 1'b0;
            o_profile_load <= 1'b0;
            o_hist_valid <= 1'b0;
            smp_q <= 1'b0;
            fbi_q <= '0;
            fbm_q <= '0;
        end else begin
            o_dco_tw <= dco_d;
            o_loop_closed <= closed_d;
            o_holdover <= hold_d;
            o_free_run <= free_d;
            o_switching <= keep_d;
            o_profile_load <= load_d;
            o_hist_valid <= avg_bus.hist_valid;
            smp_q <= smp_d;
            fbi_q <= i_fb_int;
            fbm_q <= i_fb_mod;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock indications; the same freeze applies to phase and frequency
    assign lk_raw = {i_freq_lock_raw, i_phase_lock_raw};
    for (genvar g = 0; g < 2; g++) begin : g_lock
        always_comb begin
            if (keep_d) begin
                lk_d[g] = lk_q[g]; // see R4
            end else begin
                lk_d[g] = is_track(st_d) ? lk_raw[g] : 1'b0; // see R11
            end
        end
        always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
                lk_q[g] <= 1'b0;
            end else begin
                lk_q[g] <= lk_d[g];
            end
        end
    end
    assign o_phase_lock = lk_q[0];
    assign o_freq_lock = lk_q[1];

    ////////////////////////////////////////////////////////////////////////
    // history averager; registered sample costs one cycle but keeps the
    // strobe free of state decode glitches
    assign avg_bus.sample_en = smp_q;
    assign avg_bus.interval_log2 = i_avg_interval;
    assign avg_bus.clear = o_free_run;

    logic [dlsc_pkg::TW_W-1:0] smp_tw_q;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            smp_tw_q <= dlsc_pkg::TW_RST;
        end else begin
            smp_tw_q <= i_loop_tw;
        end
    end
    assign avg_bus.sample = smp_tw_q;

    dlsc_tw_avg u_avg (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .bus(avg_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    a_hold_word_const: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R2
        o_holdover && $past(o_holdover) |-> $stable(o_dco_tw))
        else $error("tuning word moved in holdover");
    a_hold_no_track: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R6
        o_holdover |-> !o_loop_closed && !smp_q)
        else $error("loop tracking while in holdover");
    a_switch_brief: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R3
        $rose(st_q == dlsc_pkg::ST_SWHOLD) |-> ##[1:6] (st_q != dlsc_pkg::ST_SWHOLD))
        else $error("switchover holdover too long");
    a_switch_lock_held: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R4
        o_switching && $past(o_switching) |-> $stable(o_phase_lock) && $stable(o_freq_lock))
        else $error("lock changed during switchover");
    a_lost_ref_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R5
        (st_q == dlsc_pkg::ST_CLOSED) && !(|i_ref_valid) && !i_user_free_run
        |=> (st_q == dlsc_pkg::ST_HOLD) && o_holdover)
        else $error("no holdover after loss of references");
    a_auto_exit: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R7
        (st_q == dlsc_pkg::ST_HOLD) && sel_ok && !i_user_holdover && !i_user_free_run
        |=> o_profile_load ##1 (st_q == dlsc_pkg::ST_RECOVER || !o_loop_closed))
        else $error("holdover not left with valid reference");
    // a fresh recovery restarts at stage zero; inside one, stages only step up
    a_recover_steps: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R8
        (st_q == dlsc_pkg::ST_RECOVER) && $changed(o_recover_stage)
        |-> (o_recover_stage == $past(o_recover_stage) + 2'h1) ||
            (($past(st_q) == dlsc_pkg::ST_LOAD) && (o_recover_stage == 2'h0)))
        else $error("recovery stage skipped");
    a_user_hold_stays: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R9
        (st_q == dlsc_pkg::ST_HOLD) && i_user_holdover |=> o_holdover || o_free_run)
        else $error("left holdover while user hold set");
    a_hold_unlocked: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R11
        (o_free_run || (st_q == dlsc_pkg::ST_HOLD)) |-> !o_phase_lock && !o_freq_lock)
        else $error("lock reported in free run or holdover");
    a_div_change_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R13
        (st_q == dlsc_pkg::ST_CLOSED) && fb_chg && !hold_req && !i_user_free_run
        |=> (st_q == dlsc_pkg::ST_SWHOLD) && o_switching)
        else $error("divider change did not open the loop");
    a_no_hist_freerun: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see R14
        $rose(o_holdover) && !$past(avg_bus.hist_valid)
        |-> o_dco_tw == $past(i_freerun_tw))
        else $error("holdover word not free-run word without history");
endmodule : dlsc_loop_ctrl

//--- verification/dlsc_ref_model.sv
// partner model: the external references and their validation monitors
// assumes one core clock; every output changes by nonblocking update
`timescale 1ns/10ps
module dlsc_ref_model #(
    parameter int LOCK_CYC = 12
) (
    input wire logic i_core_clk,
    input wire logic i_slow,
    input wire logic [dlsc_pkg::NREF-1:0] i_want_valid,
    output logic [dlsc_pkg::NREF-1:0] o_ref_valid,
    output logic [dlsc_pkg::SEL_W-1:0] o_ref_sel,
    output logic o_phase_lock_raw,
    output logic o_freq_lock_raw
);
    logic [dlsc_pkg::NREF-1:0] vld_q = '0;
    logic [dlsc_pkg::SEL_W-1:0] nsel;
    int lock_cnt = 0;

    ////////////////////////////////////////////////////////////////////////
    // no reference is qualified before the bench asks for one
    initial begin
        o_ref_valid = '0;
        o_ref_sel = '0;
    end

    // lowest valid index wins; with none valid the old choice stands
    always_comb begin
        nsel = o_ref_sel;
        for (int i = dlsc_pkg::NREF - 1; i >= 0; i--) begin
            if (o_ref_valid[i]) begin
                nsel = i[dlsc_pkg::SEL_W-1:0];
            end
        end
    end

    // a slow monitor qualifies one cycle later; a new choice restarts
    // lock, since the loop has not yet pulled in on the new reference
    always @(posedge i_core_clk) begin
        vld_q <= i_want_valid;
        o_ref_valid <= i_slow ? vld_q : i_want_valid;
        o_ref_sel <= nsel;
        if (nsel != o_ref_sel || !o_ref_valid[nsel]) begin
            lock_cnt <= 0;
        end else if (lock_cnt < LOCK_CYC) begin
            lock_cnt <= lock_cnt + 1;
        end
    end

    // frequency lock comes in before phase lock
    assign o_phase_lock_raw = (lock_cnt == LOCK_CYC);
    assign o_freq_lock_raw = (lock_cnt >= LOCK_CYC / 2);
endmodule : dlsc_ref_model

//--- verification/dpll_loop_state_controller_tb_top.sv
// testbench of the dpll loop state controller with a reference model
// assumes inputs change at the falling edge and outputs settle by then
`timescale 1ns/10ps
module dpll_loop_state_controller_tb_top;
    logic clk, rst = 1'b1, uhold = 1'b0, ufree = 1'b1, strobe = 1'b0, slow = 1'b0;
    logic [31:0] loop_tw = '0, free_tw = '0, m_avg = '0;
    logic [3:0] intv = 4'h2, want = 4'h0;
    logic [16:0] fb_int = 17'h0_0100;
    logic [22:0] fb_mod = 23'h00_1000;
    logic [3:0] vld, flags;
    logic [1:0] sel, pidx, stage;
    logic plr, flr, closed, hold, free, sw, pload, plock, flock, hist, m_hist = 1'b0;
    logic [31:0] dco, m_q[$];
    int num_errors = 0, tests_run = 0;

    ////////////////////////////////////////////////////////////////////////
    // 50 MHz core clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    dlsc_ref_model i_ref (.i_core_clk(clk), .i_slow(slow), .i_want_valid(want),
        .o_ref_valid(vld), .o_ref_sel(sel), .o_phase_lock_raw(plr), .o_freq_lock_raw(flr));

    dlsc_loop_ctrl i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_ref_valid(vld),
        .i_ref_sel(sel), .i_user_holdover(uhold), .i_user_free_run(ufree),
        .i_tw_strobe(strobe), .i_loop_tw(loop_tw), .i_freerun_tw(free_tw),
        .i_avg_interval(intv), .i_fb_int(fb_int), .i_fb_mod(fb_mod),
        .i_phase_lock_raw(plr), .i_freq_lock_raw(flr), .o_dco_tw(dco),
        .o_loop_closed(closed), .o_holdover(hold), .o_free_run(free),
        .o_switching(sw), .o_profile_load(pload), .o_profile_idx(pidx),
        .o_recover_stage(stage), .o_phase_lock(plock), .o_freq_lock(flock),
        .o_hist_valid(hist));

    // flags that the bench waits on: 0 hold, 1 switching, 2 load, 3 closed
    assign flags = {closed, pload, sw, hold};

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // bounded wait, since partner latency makes some causes late
    task automatic wait_hi(input int w);
        int k;
        k = 0;
        while (flags[w] !== 1'b1 && k < 300) begin
            tick(1);
            k++;
        end
        chk("flag_seen", 1, flags[w]);
    endtask : wait_hi

    // strobes back to back; the model averages whole blocks, truncated
    task automatic send(input int n, input logic lp);
        logic [31:0] w;
        longint s;
        for (int i = 0; i < n; i++) begin
            w = $urandom;
            strobe = 1'b1;
            loop_tw = w;
            tick(1);
            if (lp) begin
                chk("dco_track", w, dco);
                m_q.push_back(w);
            end else begin
                chk("dco_frozen", m_avg, dco);
            end
            if (m_q.size() == (1 << intv)) begin
                s = 0;
                foreach (m_q[j]) s += m_q[j];
                m_avg = 32'(s >> intv);
                m_hist = 1'b1;
                m_q.delete();
            end
        end
        strobe = 1'b0;
    endtask : send

    // called at the load cycle; three stages of ten cycles, then tracking
    task automatic chk_recover(input logic [1:0] idx, input logic swo, input logic lk);
        chk("load", 1, pload);
        chk("idx", idx, pidx);
        for (int i = 1; i <= 31; i++) begin
            tick(1);
            chk("closed", 1, closed);
            chk("holdover", 0, hold);
            chk("switching", swo && i < 31, sw);
            if (i == 1) chk("load_pulse", 0, pload);
            if (i <= 30) chk("stage", (i - 1) / 10, stage);
            if (swo && i < 31) chk("lock_held", lk, plock);
        end
    endtask : chk_recover

    // five cycles of brief holdover with the lock outputs frozen
    task automatic do_switch(input logic [1:0] idx);
        logic lk;
        lk = plock;
        wait_hi(1);
        for (int i = 1; i <= 5; i++) begin
            chk("sw_hold", 1, hold);
            chk("sw_open", 0, closed);
            chk("sw_lock", lk, plock);
            tick(1);
        end
        chk_recover(idx, 1'b1, lk);
    endtask : do_switch

    ////////////////////////////////////////////////////////////////////////
    // cuts a hang short well beyond the expected run length
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    // main sequence
    initial begin
        void'($urandom(32'h2a1f8fd9));
        free_tw = $urandom;
        want = 4'b0010;
        tick(16);
        rst = 1'b0;
        chk("rst_free", 1, free);
        chk("rst_lock", 0, plock);
        chk("rst_dco", 0, dco);
        ufree = 1'b0;
        wait_hi(2);
        chk_recover(2'h1, 1'b0, 1'b0);
        send(4, 1'b1);
        tick(4);
        chk("hist", m_hist, hist);
        uhold = 1'b1;
        tick(1);
        chk("uh_hold", 1, hold);
        chk("uh_plock", 0, plock);
        chk("uh_flock", 0, flock);
        chk("uh_dco", m_avg, dco);
        send(3, 1'b0);
        tick(20);
        chk("uh_stays", 1, hold);
        uhold = 1'b0;
        wait_hi(2);
        chk_recover(2'h1, 1'b0, 1'b0);
        tick(15);
        chk("lock_raw", plr, plock);
        slow = 1'b1;
        want = 4'b0011;
        do_switch(2'h0);
        for (int j = 0; j < 2; j++) begin
            tick(15);
            if (j == 0) fb_int = fb_int + 17'h0_0001;
            else fb_mod = fb_mod + 23'h00_0001;
            do_switch(2'h0);
        end
        intv = 4'h0;
        send(1, 1'b1);
        // the averager takes a sample two edges after its strobe
        tick(2);
        intv = 4'h3;
        send(8, 1'b1);
        tick(4);
        chk("hist", m_hist, hist);
        want = 4'b0000;
        wait_hi(0);
        chk("loss_lock", 0, plock);
        chk("loss_dco", m_avg, dco);
        want = 4'b0100;
        wait_hi(2);
        chk_recover(2'h2, 1'b0, 1'b0);
        ufree = 1'b1;
        uhold = 1'b1;
        tick(1);
        chk("fr_free", 1, free);
        chk("fr_hold", 0, hold);
        chk("fr_lock", 0, plock);
        m_hist = 1'b0;
        tick(4);
        chk("fr_hist", m_hist, hist);
        ufree = 1'b0;
        wait_hi(0);
        chk("nohist_dco", free_tw, dco);
        uhold = 1'b0;
        wait_hi(2);
        chk_recover(2'h2, 1'b0, 1'b0);
        print_verdict();
    end
endmodule : dpll_loop_state_controller_tb_top
